// >>> i2cs_params.svh
// Purpose: Constants of the two-wire slave with command pointer.
// Assumes: Included by bare name wherever the constants are needed.
// Notes: Holds definitions only.
`ifndef I2CS_PARAMS_SVH
`define I2CS_PARAMS_SVH

`define I2CS_ADDR_FIXED   3'h4
`define I2CS_PTR_HOLD     7'h7f
`define I2CS_PTR_RESET    8'h00
`define I2CS_LAST_BIT     4'h7
`define I2CS_ACK_SLOT     4'h8
`define I2CS_SYNC_STAGES  2

`endif

// >>> i2cs_pkg.sv
// Purpose: Types shared by the two-wire slave modules.
// Assumes: Nothing beyond a SystemVerilog compiler.
// Notes: Constants live in i2cs_params.svh.
package i2cs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100
    } i2cs_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic selHigh;
        logic selLow;
    } i2cs_pins_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } i2cs_wr_t;

endpackage

// >>> i2cs_sync.sv
// Purpose: Multi-stage synchroniser for pin levels.
// Assumes: Inputs are asynchronous levels, idle high.
// Notes: Only the last stage may be read by other logic.
`timescale 1ns/10ps
`default_nettype none
module i2cs_sync #(
    parameter int W      = 4,
    parameter int STAGES = 2
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async,
    output logic      [W-1:0] sync
);
    if (STAGES < 2) begin : g_bad_stages
        $error("i2cs_sync needs at least two stages");
    end

    logic [W-1:0] stage_q [STAGES];

    // Reset to high so an idle bus cannot look like a START.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_q[i] <= '1;
            end
        end else begin
            stage_q[0] <= async;
            for (int i = 1; i < STAGES; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign sync = stage_q[STAGES-1];
endmodule // i2cs_sync
`default_nettype wire

// >>> i2cs_pin_decode.sv
// Purpose: Senses which of four nets an address select pin is tied to.
// Assumes: Pin, data and clock levels are synchronised alike.
// Notes: Observation restarts at every START.
`timescale 1ns/10ps
`default_nettype none
module i2cs_pin_decode (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       pinLvl,
    input  wire logic       sdaLvl,
    input  wire logic       sclLvl,
    output logic      [1:0] code
);
    logic sawLow_q;
    logic sawHigh_q;
    logic offSda_q;
    logic offScl_q;
    logic [1:0] code_q;
    logic [1:0] code_d;
    logic toggled;

    assign toggled = sawLow_q && sawHigh_q;
    // A tied-to-supply pin never toggles; a bus-tied pin follows its net.
    assign code_d = !toggled ? (pinLvl ? 2'h1 : 2'h0) :
                    !offScl_q ? 2'h3 :
                    !offSda_q ? 2'h2 : 2'h0;

    always_ff @(posedge core_clk) begin
        if (rst || clear) begin
            sawLow_q  <= 1'b0;
            sawHigh_q <= 1'b0;
            offSda_q  <= 1'b0;
            offScl_q  <= 1'b0;
        end else begin
            sawLow_q  <= sawLow_q || !pinLvl;
            sawHigh_q <= sawHigh_q || pinLvl;
            offSda_q  <= offSda_q || (pinLvl != sdaLvl);
            offScl_q  <= offScl_q || (pinLvl != sclLvl);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            code_q <= 2'h0;
        end else begin
            code_q <= code_d;
        end
    end

    assign code = code_q;
endmodule // i2cs_pin_decode
`default_nettype wire

// >>> i2cs_slave.sv
// Purpose: Two-wire slave with stored command pointer and autoincrement.
// Assumes: Core clock is much faster than the bus clock.
// Notes: Register storage sits outside; this block only sequences it.
// Function
// - Master starts all transfers and clocks them; device stays slave.
// - Clock line is input only; device never drives or stretches it.
// - Data line is sampled and only pulled low, never driven high.
// - Order is START, address with direction, command, data, STOP.
// - START is data falling while clock high; device detects it.
// - STOP is data rising while clock high; bus then free.
// - One bit per clock pulse; data stable while clock high.
// - Ninth clocked bit is acknowledge, held low through clock high.
// - Device acknowledges written bytes; master acknowledges read bytes.
// - Eighth address bit is direction: zero write, one read.
// - Address top bits fixed at 100; low four from select pins.
// - Each select pin senses ground, supply, data, clock as 0..3.
// - First byte after write address is the command byte.
// - STOP after command byte only stores the pointer.
// - Data bytes go to pointer register, then following registers.
// - Pointer below 7f in low bits increments after each byte.
// - Pointer at 7f in low bits stays unchanged after each byte.
// - Reads use the same stored pointer and increment rules.
// - Top bit of command byte is ignored for register selection.
`timescale 1ns/10ps
`default_nettype none
`include "i2cs_params.svh"
module i2cs_slave
    import i2cs_pkg::*;
#(
    parameter int SYNC_STAGES = `I2CS_SYNC_STAGES
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOeN,
    input  wire logic       addrSelectPinHigh,
    input  wire logic       addrSelectPinLow,
    output logic      [6:0] regAddr,
    output i2cs_wr_t        wrReq,
    output logic            wrStrobe,
    input  wire logic [7:0] rdData,
    output logic            rdStrobe,
    output logic            busBusy
);
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("i2cs_slave needs at least two synchroniser stages");
    end

    i2cs_pins_t  pinsRaw;
    i2cs_pins_t  pinsSync;
    i2cs_state_t state_q;
    i2cs_state_t state_d;
    logic        sclPrev_q;
    logic        sdaPrev_q;
    logic [3:0]  bitCnt_q;
    logic [3:0]  bitCnt_d;
    logic [7:0]  shift_q;
    logic [7:0]  shift_d;
    logic [7:0]  tx_q;
    logic [7:0]  tx_d;
    logic [7:0]  pointer_q;
    logic [7:0]  pointer_d;
    logic        ackPend_q;
    logic        ackPend_d;
    logic        pullLow_q;
    logic        pullLow_d;
    i2cs_wr_t    wrReq_q;
    i2cs_wr_t    wrReq_d;
    logic        wrStrobe_q;
    logic        wrStrobe_d;
    logic        rdStrobe_q;
    logic        rdStrobe_d;
    logic        busy_q;
    logic [1:0]  selHighCode;
    logic [1:0]  selLowCode;

    // The clock pin has no output path at all; it is only ever sampled.
    assign pinsRaw = '{scl: sclIn, sda: sdaIn,
                       selHigh: addrSelectPinHigh,
                       selLow: addrSelectPinLow};

    i2cs_sync #(
        .W      (4),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async    (pinsRaw),
        .sync     (pinsSync)
    );

    wire sclS     = pinsSync.scl;
    wire sdaS     = pinsSync.sda;
    wire sclRise  = sclS && !sclPrev_q;
    wire sclFall  = !sclS && sclPrev_q;
    wire startDet = sclS && sclPrev_q && sdaPrev_q && !sdaS;
    wire stopDet  = sclS && sclPrev_q && !sdaPrev_q && sdaS;
    wire ackSlot  = (bitCnt_q == `I2CS_ACK_SLOT);
    wire byteDone = sclRise && (bitCnt_q == `I2CS_LAST_BIT);
    // Bits arrive MSB first, so each new bit enters at the bottom.
    wire [7:0] shiftIn = {shift_q[6:0], sdaS};

    i2cs_pin_decode u_dec_high (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (startDet),
        .pinLvl   (pinsSync.selHigh),
        .sdaLvl   (sdaS),
        .sclLvl   (sclS),
        .code     (selHighCode)
    );

    i2cs_pin_decode u_dec_low (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (startDet),
        .pinLvl   (pinsSync.selLow),
        .sdaLvl   (sdaS),
        .sclLvl   (sclS),
        .code     (selLowCode)
    );

    wire [6:0] ownAddr   = {`I2CS_ADDR_FIXED, selHighCode, selLowCode};
    wire       addrMatch = (shiftIn[7:1] == ownAddr);
    wire       isRead    = shiftIn[0];
    wire       ptrAtHold = (pointer_q[6:0] == `I2CS_PTR_HOLD);
    // Only the low seven bits take part; the top bit rides along unchanged.
    wire [6:0] ptrLowNext = ptrAtHold ? pointer_q[6:0] :
                            7'(pointer_q[6:0] + 7'h01);
    wire [7:0] ptrNext    = {pointer_q[7], ptrLowNext};

    always_comb begin
        state_d    = state_q;
        bitCnt_d   = bitCnt_q;
        shift_d    = shift_q;
        tx_d       = tx_q;
        pointer_d  = pointer_q;
        ackPend_d  = ackPend_q;
        pullLow_d  = pullLow_q;
        wrReq_d    = wrReq_q;
        wrStrobe_d = 1'b0;
        rdStrobe_d = 1'b0;
        if (startDet) begin
            // Repeated START is handled the same as a first one.
            state_d   = ST_ADDR;
            bitCnt_d  = 4'h0;
            ackPend_d = 1'b0;
            pullLow_d = 1'b0;
        end else if (stopDet) begin
            // A STOP right after the command byte leaves only the pointer.
            state_d   = ST_IDLE;
            bitCnt_d  = 4'h0;
            ackPend_d = 1'b0;
            pullLow_d = 1'b0;
        end else if (state_q != ST_IDLE) begin
            if (sclRise) begin
                if (ackSlot) begin
                    bitCnt_d  = 4'h0;
                    ackPend_d = 1'b0;
                    // The master acknowledges read bytes; high ends the read.
                    if (!ackPend_q && state_q == ST_RDATA) begin
                        pointer_d = ptrNext;
                        if (sdaS) begin
                            state_d = ST_IDLE;
                        end
                    end
                end else begin
                    shift_d  = shiftIn;
                    bitCnt_d = 4'(bitCnt_q + 4'h1);
                    if (byteDone) begin
                        case (state_q)
                            ST_ADDR: begin
                                if (addrMatch) begin
                                    ackPend_d = 1'b1;
                                    state_d   = isRead ? ST_RDATA : ST_CMD;
                                end else begin
                                    state_d = ST_IDLE;
                                end
                            end
                            ST_CMD: begin
                                pointer_d = shiftIn;
                                ackPend_d = 1'b1;
                                state_d   = ST_WDATA;
                            end
                            ST_WDATA: begin
                                wrReq_d.addr = pointer_q[6:0];
                                wrReq_d.data = shiftIn;
                                wrStrobe_d   = 1'b1;
                                pointer_d    = ptrNext;
                                ackPend_d    = 1'b1;
                            end
                            default: begin
                                ackPend_d = 1'b0;
                            end
                        endcase
                    end
                end
            end else if (sclFall) begin
                // Changes only follow a falling clock, so SDA is stable while SCL is high.
                if (ackSlot) begin
                    pullLow_d = ackPend_q;
                end else if (state_q == ST_RDATA && bitCnt_q == 4'h0) begin
                    tx_d       = {rdData[6:0], 1'b1};
                    pullLow_d  = !rdData[7];
                    rdStrobe_d = 1'b1;
                end else if (state_q == ST_RDATA) begin
                    tx_d      = {tx_q[6:0], 1'b1};
                    pullLow_d = !tx_q[7];
                end else begin
                    pullLow_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            bitCnt_q  <= 4'h0;
            shift_q   <= 8'h00;
            tx_q      <= 8'hff;
            ackPend_q <= 1'b0;
            pullLow_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            bitCnt_q  <= bitCnt_d;
            shift_q   <= shift_d;
            tx_q      <= tx_d;
            ackPend_q <= ackPend_d;
            pullLow_q <= pullLow_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pointer_q  <= `I2CS_PTR_RESET;
            wrReq_q    <= '0;
            wrStrobe_q <= 1'b0;
            rdStrobe_q <= 1'b0;
        end else begin
            pointer_q  <= pointer_d;
            wrReq_q    <= wrReq_d;
            wrStrobe_q <= wrStrobe_d;
            rdStrobe_q <= rdStrobe_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            busy_q    <= 1'b0;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
            busy_q    <= startDet ? 1'b1 : (stopDet ? 1'b0 : busy_q);
        end
    end

    // Open drain: the pad level is always low, only the enable moves.
    assign sdaOut   = 1'b0;
    assign sdaOeN   = !pullLow_q;
    assign regAddr  = pointer_q[6:0];
    assign wrReq    = wrReq_q;
    assign wrStrobe = wrStrobe_q;
    assign rdStrobe = rdStrobe_q;
    assign busBusy  = busy_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_start_restart: assert property (startDet |=>
        state_q == ST_ADDR && bitCnt_q == 4'h0 && !pullLow_q)
        else $error("START did not restart address phase");

    chk_stop_release: assert property (stopDet |=>
        state_q == ST_IDLE && !pullLow_q && !busy_q)
        else $error("STOP did not free the bus");

    chk_drive_on_fall: assert property ($rose(pullLow_q) |->
        $past(sclFall) && !sclS)
        else $error("SDA pulled low outside clock low phase");

    chk_ack_slot_only: assert property (
        $rose(pullLow_q) && state_q != ST_RDATA |-> bitCnt_q == 4'h8)
        else $error("SDA pulled low outside ack slot");

    chk_foreign_ignored: assert property (
        byteDone && state_q == ST_ADDR && !addrMatch |=>
        state_q == ST_IDLE && !ackPend_q ##1 !pullLow_q)
        else $error("foreign address was answered");

    chk_dir_decode: assert property (
        byteDone && state_q == ST_ADDR && addrMatch |=>
        state_q == ($past(shiftIn[0]) ? ST_RDATA : ST_CMD) && ackPend_q)
        else $error("direction bit decoded wrongly");

    chk_cmd_store: assert property (
        byteDone && state_q == ST_CMD && !startDet && !stopDet |=>
        pointer_q == $past(shiftIn) && state_q == ST_WDATA)
        else $error("command byte not stored as pointer");

    chk_write_strobe: assert property (
        wrStrobe_q |-> $past(state_q == ST_WDATA && byteDone) &&
        wrReq_q.addr == $past(pointer_q[6:0]))
        else $error("write strobe without a data byte");

    chk_ptr_inc: assert property (
        wrStrobe_q && wrReq_q.addr != 7'h7f |->
        pointer_q[6:0] == 7'(wrReq_q.addr + 7'h01))
        else $error("pointer did not increment");

    chk_ptr_hold: assert property (
        wrStrobe_q && wrReq_q.addr == 7'h7f |-> pointer_q[6:0] == 7'h7f)
        else $error("pointer left the hold value");

    chk_read_nack_end: assert property (
        sclRise && ackSlot && state_q == ST_RDATA && !ackPend_q && sdaS
        && !startDet && !stopDet |=> state_q == ST_IDLE ##1 !pullLow_q)
        else $error("read continued after master NACK");

    chk_idle_release: assert property (
        state_q == ST_IDLE && !pullLow_q |=> !pullLow_q)
        else $error("SDA pulled low while idle");

    cov_write_byte: cover property (wrStrobe_q ##[1:400] stopDet);
    cov_read_ack: cover property (rdStrobe_q ##[1:400] rdStrobe_q);
    cov_foreign: cover property (byteDone && state_q == ST_ADDR && !addrMatch);
    cov_hold: cover property (wrStrobe_q && wrReq_q.addr == 7'h7f);
endmodule // i2cs_slave
`default_nettype wire

// >>> i2cs_bus_master.sv
// Purpose: Behavioural two-wire bus master that drives the slave's pins.
// Assumes: The data line has a pull-up and the slave only pulls it low.
// Notes: The testbench calls the tasks; SCL stands high between frames.
`timescale 1ns/10ps
`default_nettype none
module i2cs_bus_master (
    output logic      scl,
    output logic      sdaRel,
    input  wire logic sdaBus
);
    int clashes;

    initial begin
        scl     = 1'h1;
        sdaRel  = 1'h1;
        clashes = 0;
    end

    // Serves from idle and as a repeated start with SCL low.
    task automatic start_cond();
        sdaRel = 1'h1;
        #16 scl = 1'h1;
        #16 sdaRel = 1'h0;
        #16 scl = 1'h0;
    endtask

    task automatic stop_cond();
        sdaRel = 1'h0;
        #16 scl = 1'h1;
        #16 sdaRel = 1'h1;
        #16;
    endtask

    // A level that moves while SCL is high is counted as a clash.
    task automatic clock_bit(input logic b, output logic seen);
        logic early;
        #16 sdaRel = b;
        #16 scl = 1'h1;
        #4 early = sdaBus;
        #24 seen = sdaBus;
        if (early !== seen) clashes++;
        #4 scl = 1'h0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], seen);
            if (seen !== b[i]) clashes++;
        end
        clock_bit(1'h1, ack);
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'h1, seen);
            b[i] = seen;
        end
        clock_bit(nack, seen);
        sdaRel = 1'h1;
    endtask
endmodule // i2cs_bus_master
`default_nettype wire

// >>> test_i2cs_slave.sv
// Purpose: Self-checking bench for the two-wire slave with command pointer.
// Assumes: The master model drives the bus at a 64 ns bit period.
// Notes: Register storage is a bench array read through regAddr.
`timescale 1ns/10ps
`default_nettype none
module test_i2cs_slave
    import i2cs_pkg::*;
;
    logic       core_clk;
    logic       rst;
    logic       sclBus;
    logic       sdaRel;
    logic       sdaOut;
    logic       sdaOeN;
    logic [1:0] codeHigh;
    logic [1:0] codeLow;
    logic [6:0] regAddr;
    i2cs_wr_t   wrReq;
    logic       wrStrobe;
    logic       rdStrobe;
    logic       busBusy;
    logic [7:0] mem [128];
    i2cs_wr_t   wrLog [$];
    int         rdCount;
    int         nFail;
    int         comparisons;

    function automatic logic pin_level(input logic [1:0] code,
                                       input logic sda, input logic scl);
        return code == 2'h0 ? 1'h0 : code == 2'h1 ? 1'h1
                                   : code == 2'h2 ? sda : scl;
    endfunction

    function automatic logic [6:0] dev_addr();
        return {3'h4, codeHigh, codeLow};
    endfunction

    wire       sdaBus  = sdaRel & (sdaOeN | sdaOut);
    wire       pinHigh = pin_level(codeHigh, sdaBus, sclBus);
    wire       pinLow  = pin_level(codeLow, sdaBus, sclBus);
    wire [7:0] rdData  = mem[regAddr];

    i2cs_slave i2cs_slave_inst (
        .core_clk          (core_clk),
        .rst               (rst),
        .sclIn             (sclBus),
        .sdaIn             (sdaBus),
        .sdaOut            (sdaOut),
        .sdaOeN            (sdaOeN),
        .addrSelectPinHigh (pinHigh),
        .addrSelectPinLow  (pinLow),
        .regAddr           (regAddr),
        .wrReq             (wrReq),
        .wrStrobe          (wrStrobe),
        .rdData            (rdData),
        .rdStrobe          (rdStrobe),
        .busBusy           (busBusy)
    );

    i2cs_bus_master i2cs_bus_master_inst (
        .scl    (sclBus),
        .sdaRel (sdaRel),
        .sdaBus (sdaBus)
    );

    initial core_clk = 1'h0;
    always #2 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (wrStrobe === 1'h1) begin
            wrLog.push_back(wrReq);
            mem[wrReq.addr] <= wrReq.data;
        end
        if (rdStrobe === 1'h1) rdCount++;
    end

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic put(input logic [7:0] b, input logic expAck);
        logic ack;
        i2cs_bus_master_inst.send_byte(b, ack);
        check("ack", {15'h0000, expAck}, {15'h0000, ack});
    endtask

    task automatic get(input logic [7:0] exp, input logic nack);
        logic [7:0] b;
        i2cs_bus_master_inst.recv_byte(nack, b);
        check("read byte", {8'h00, exp}, {8'h00, b});
    endtask

    task automatic begin_frame();
        @(posedge core_clk);
        #1;
        wrLog.delete();
        rdCount = 0;
        i2cs_bus_master_inst.start_cond();
    endtask

    task automatic end_frame();
        i2cs_bus_master_inst.stop_cond();
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic test_write_burst();
        logic [14:0] exp [3];
        exp = '{15'h7ea1, 15'h7fb2, 15'h7fc3};
        codeHigh = 2'h2;
        codeLow  = 2'h3;
        begin_frame();
        put({dev_addr(), 1'h0}, 1'h0);
        check("busy", 16'h0001, {15'h0000, busBusy});
        put(8'hfe, 1'h0);
        put(8'ha1, 1'h0);
        put(8'hb2, 1'h0);
        put(8'hc3, 1'h0);
        end_frame();
        check("busy", 16'h0000, {15'h0000, busBusy});
        check("writes", 16'h0003, 16'(wrLog.size()));
        for (int i = 0; i < wrLog.size() && i < 3; i++)
            check("write", {1'h0, exp[i]}, {1'h0, wrLog[i]});
        check("pointer", 16'h007f, {9'h000, regAddr});
    endtask

    task automatic test_cmd_only();
        codeHigh = 2'h0;
        codeLow  = 2'h1;
        begin_frame();
        put({dev_addr(), 1'h0}, 1'h0);
        put(8'h05, 1'h0);
        end_frame();
        check("writes", 16'h0000, 16'(wrLog.size()));
        check("pointer", 16'h0005, {9'h000, regAddr});
    endtask

    task automatic test_read_back();
        codeHigh = 2'h1;
        codeLow  = 2'h0;
        begin_frame();
        put({dev_addr(), 1'h0}, 1'h0);
        put(8'h7e, 1'h0);
        i2cs_bus_master_inst.start_cond();
        put({dev_addr(), 1'h1}, 1'h0);
        get(8'ha1, 1'h0);
        get(8'hc3, 1'h0);
        get(8'hc3, 1'h1);
        end_frame();
        check("reads", 16'h0003, 16'(rdCount));
        check("writes", 16'h0000, 16'(wrLog.size()));
        check("pointer", 16'h007f, {9'h000, regAddr});
    endtask

    task automatic test_foreign();
        codeHigh = 2'h3;
        codeLow  = 2'h3;
        begin_frame();
        put(8'h1e, 1'h1);
        put(8'h22, 1'h1);
        end_frame();
        check("writes", 16'h0000, 16'(wrLog.size()));
        begin_frame();
        put(8'h9c, 1'h1);
        end_frame();
        begin_frame();
        put(8'h9e, 1'h0);
        put(8'h30, 1'h0);
        end_frame();
        check("pointer", 16'h0030, {9'h000, regAddr});
    endtask

    // Every pairing of the two select pins must yield its own address.
    task automatic test_all_pins();
        for (int c = 0; c < 16; c++) begin
            codeHigh = c[3:2];
            codeLow  = c[1:0];
            begin_frame();
            put({dev_addr(), 1'h0}, 1'h0);
            end_frame();
        end
    endtask

    task automatic report_and_stop();
        if (nFail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        rst         = 1'h1;
        codeHigh    = 2'h1;
        codeLow     = 2'h1;
        nFail       = 0;
        comparisons = 0;
        rdCount     = 0;
        for (int i = 0; i < 128; i++) mem[i] = 8'h00;
        repeat (12) @(posedge core_clk);
        #1 rst = 1'h0;
        repeat (4) @(posedge core_clk);
        #1;
        check("idle", 16'h0003, {14'h0000, sdaOeN, ~busBusy});
        check("pointer", 16'h0000, {9'h000, regAddr});
        test_write_burst();
        test_cmd_only();
        test_read_back();
        test_foreign();
        test_all_pins();
        check("clash", 16'h0000, 16'(i2cs_bus_master_inst.clashes));
        check("pad value", 16'h0000, {15'h0000, sdaOut});
        report_and_stop();
    end

    // The tests need about 22 us; nine times that means a hang.
    initial begin
        #200000;
        nFail++;
        report_and_stop();
    end
endmodule // test_i2cs_slave
`default_nettype wire
